// file: cabe_pkg.sv
// Constants and carrier types of the execution block
//
// Contract
// - Add and add-with-carry: one cycle, ZCNVH
// - Word immediate add/subtract: two cycles, ZCNVS
// - Byte subtract, optional borrow: one cycle, ZCNVH
// - AND/OR/XOR one cycle, ZNV, carry kept
// - Clear-bits ANDs complement; self-test ANDs itself
// - Multiply variants into R1:R0, two cycles, ZC
// - Fractional multiply shifts product left once
// - Near call: PC+offset+1, three cycles, flags kept
// - Pointer jump loads PC from Z, two cycles
// - Equal-skip compare: PC+2/3, 1/2/3 cycles
// - Compares set ZNVCH, store nothing, one cycle
// - Register bit skips on clear or set
// - I/O bit skips, same timing as register
// - Flag branch adds offset+1 when bit matches
// - Signed branches use N xor V
// - Same-higher/lower branches follow carry clear/set
// - H, T, V, I branches in both senses
// - I/O bit set/clear only at 0x00-0x1F
// - I/O bit set/clear is whole-register read-modify-write
// - Self-test sets flags; clear XORs register itself
package cabe_pkg;

   // ******
   // Register offsets and reset values
   // ******
   localparam logic [5:0] CABE_SPL_OFS = 6'h3d;
   localparam logic [5:0] CABE_SPH_OFS = 6'h3e;
   localparam logic [5:0] CABE_STATUS_FLAGS_OFS = 6'h3f;
   localparam logic [7:0] CABE_STATUS_FLAGS_RST = 8'h00;
   localparam logic [15:0] CABE_SP_RST = 16'h0000;

   // ******
   // Status flag positions
   // ******
   localparam int unsigned CABE_FLAG_C = 0;
   localparam int unsigned CABE_FLAG_Z = 1;
   localparam int unsigned CABE_FLAG_N = 2;
   localparam int unsigned CABE_FLAG_V = 3;
   localparam int unsigned CABE_FLAG_S = 4;
   localparam int unsigned CABE_FLAG_H = 5;
   localparam int unsigned CABE_FLAG_T = 6;
   localparam int unsigned CABE_FLAG_I = 7;

   // ******
   // Limits and cycle counts
   // ******
   localparam logic [5:0] CABE_IO_BIT_MAX = 6'h1f;
   localparam logic [7:0] CABE_BYTE_ONES = 8'hff;
   localparam int unsigned CABE_PC_W = 12;
   localparam logic [1:0] CABE_CYC_ONE = 2'h1;
   localparam logic [1:0] CABE_CYC_TWO = 2'h2;
   localparam logic [1:0] CABE_CYC_THREE = 2'h3;
   localparam logic [15:0] CABE_CALL_SP_STEP = 16'h0002;

   // ******
   // Operation codes
   // ******
   typedef enum logic [5:0] {
      op_none,
      op_sum,
      op_sum_carry,
      op_minus,
      op_minus_regs_borrow,
      op_and,
      op_or,
      op_xor,
      op_mask_clear_bits,
      op_self_and_check,
      op_self_xor_clear,
      op_word_imm_sum,
      op_word_imm_minus,
      op_compare,
      op_compare_carry,
      op_product_unsigned,
      op_product_signed,
      op_product_mixed,
      op_frac_product_unsigned,
      op_frac_product_signed,
      op_frac_product_mixed,
      op_near_call,
      op_jump_via_pointer,
      op_equal_skip_compare,
      op_skip_reg_bit_clear,
      op_skip_reg_bit_set,
      op_skip_io_bit_clear,
      op_skip_io_bit_set,
      op_branch_flag_set,
      op_branch_flag_clear,
      op_branch_signed_ge,
      op_branch_signed_lt,
      op_branch_same_higher,
      op_branch_lower,
      op_io_bit_set,
      op_io_bit_clear
   } cabe_op_t;

   // ******
   // Carriers
   // ******
   typedef struct packed {
      cabe_op_t op;
      logic use_imm;
      logic [4:0] dst_idx;
      logic [7:0] dst_val;
      logic [7:0] src_val;
      logic [7:0] imm;
      logic [2:0] bit_sel;
      logic [CABE_PC_W-1:0] offset;
      logic [CABE_PC_W-1:0] pc;
      logic [15:0] pair_val;
      logic [15:0] z_ptr;
      logic [5:0] io_addr;
      logic [7:0] io_val;
      logic skip_two_word;
   } cabe_cmd_t;

   typedef struct packed {
      logic reg_we;
      logic [4:0] reg_idx;
      logic [7:0] reg_data;
      logic pair_we;
      logic [4:0] pair_idx;
      logic [15:0] pair_data;
   } cabe_wb_t;

   typedef struct packed {
      logic pc_load;
      logic [CABE_PC_W-1:0] pc;
      logic push_we;
      logic [15:0] push_addr;
      logic [CABE_PC_W-1:0] push_data;
   } cabe_flow_t;

   typedef struct packed {
      logic io_we;
      logic [5:0] io_addr;
      logic [7:0] io_data;
   } cabe_io_t;

endpackage

// file: cabe_byte_arith.sv
// Eight-bit adder and subtractor with carry, half carry and overflow
module cabe_byte_arith
   import cabe_pkg::*;
(
   input wire logic [7:0] a,
   input wire logic [7:0] b,
   input wire logic cin,
   input wire logic sub,
   output logic [7:0] res,
   output logic carry,
   output logic half,
   output logic ovf
);

   logic [7:0] b_eff;
   logic c_eff;
   logic [8:0] full;
   logic [4:0] low;

   always_comb begin
      b_eff = sub ? ~b : b;
      c_eff = sub ? ~cin : cin;
      full = {1'b0, a} + {1'b0, b_eff} + {8'h00, c_eff};
      low = {1'b0, a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, c_eff};
      res = full[7:0];
      // Borrow is the inverted carry when subtracting
      carry = sub ? ~full[8] : full[8];
      half = sub ? ~low[4] : low[4];
      if (sub) begin
         ovf = (a[7] & ~b[7] & ~res[7]) | (~a[7] & b[7] & res[7]);
      end else begin
         ovf = (a[7] & b[7] & ~res[7]) | (~a[7] & ~b[7] & res[7]);
      end
   end

endmodule

// file: cabe_exec.sv
// Execution datapath for arithmetic, logic, branch, compare and skip operations
//
// Strobed register access was left to the implementer.
module cabe_exec
   import cabe_pkg::*;
#(
   parameter int unsigned SP_W = 10
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic cmd_valid,
   input wire cabe_cmd_t cmd,
   output logic cmd_ready,
   output logic done,
   output cabe_wb_t wb,
   output cabe_flow_t flow,
   output cabe_io_t io_wr,
   output logic io_refused,
   output logic [7:0] status_flags_out,
   output logic [15:0] stack_ptr_out,
   input wire logic [5:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata
);

   // ******
   // Parameter check
   // ******
   if (SP_W < 9 || SP_W > 16) begin : g_bad_sp
      $error("stack pointer width must lie between 9 and 16");
   end

   // ******
   // State
   // ******
   logic [7:0] status_flags;
   logic [15:0] stack_ptr;
   logic [1:0] cyc_left;
   logic accept;

   logic [7:0] next_flags;
   cabe_wb_t next_wb;
   cabe_flow_t next_flow;
   cabe_io_t next_io;
   logic next_refused;
   logic next_sp_call;
   logic [1:0] next_cycles;

   // ******
   // Operand shaping
   // ******
   logic [7:0] opnd_b;
   logic arith_sub;
   logic arith_cin;
   logic [7:0] arith_res;
   logic arith_c;
   logic arith_h;
   logic arith_v;
   logic [15:0] word_sum;
   logic [15:0] word_dif;
   logic signed [17:0] mul_a;
   logic signed [17:0] mul_b;
   logic signed [35:0] mul_full;
   logic [15:0] mul_p;
   logic [15:0] mul_out;
   logic is_frac;
   logic [CABE_PC_W-1:0] pc_plus1;
   logic [CABE_PC_W-1:0] pc_rel;
   logic [CABE_PC_W-1:0] pc_skip;
   logic [1:0] skip_cycles;
   logic io_ok;
   logic [7:0] bit_mask;

   assign accept = cmd_valid & cmd_ready;

   always_comb begin
      opnd_b = cmd.use_imm ? cmd.imm : cmd.src_val;
      arith_sub = (cmd.op != op_sum) && (cmd.op != op_sum_carry);
      arith_cin = 1'b0;
      if (cmd.op == op_sum_carry || cmd.op == op_minus_regs_borrow ||
          cmd.op == op_compare_carry) begin
         arith_cin = status_flags[CABE_FLAG_C];
      end
   end

   cabe_byte_arith u_arith (
      .a(cmd.dst_val),
      .b(opnd_b),
      .cin(arith_cin),
      .sub(arith_sub),
      .res(arith_res),
      .carry(arith_c),
      .half(arith_h),
      .ovf(arith_v)
   );

   always_comb begin
      word_sum = cmd.pair_val + {8'h00, cmd.imm};
      word_dif = cmd.pair_val - {8'h00, cmd.imm};
      is_frac = (cmd.op == op_frac_product_unsigned) || (cmd.op == op_frac_product_signed) ||
                (cmd.op == op_frac_product_mixed);
      mul_a = {10'h000, cmd.dst_val};
      mul_b = {10'h000, cmd.src_val};
      if (cmd.op inside {op_product_signed, op_frac_product_signed, op_product_mixed,
                         op_frac_product_mixed}) begin
         mul_a = {{10{cmd.dst_val[7]}}, cmd.dst_val};
      end
      if (cmd.op == op_product_signed || cmd.op == op_frac_product_signed) begin
         mul_b = {{10{cmd.src_val[7]}}, cmd.src_val};
      end
      mul_full = mul_a * mul_b;
      mul_p = mul_full[15:0];
      mul_out = is_frac ? {mul_p[14:0], 1'b0} : mul_p;
      pc_plus1 = cmd.pc + CABE_PC_W'(1);
      pc_rel = cmd.pc + cmd.offset + CABE_PC_W'(1);
      pc_skip = cmd.skip_two_word ? cmd.pc + CABE_PC_W'(3) : cmd.pc + CABE_PC_W'(2);
      skip_cycles = cmd.skip_two_word ? CABE_CYC_THREE : CABE_CYC_TWO;
      io_ok = cmd.io_addr <= CABE_IO_BIT_MAX;
      bit_mask = 8'h01 << cmd.bit_sel;
   end

   // ******
   // Flag helpers
   // ******
   function automatic logic [7:0] logic_flags(input logic [7:0] old, input logic [7:0] r);
      logic [7:0] f;
      f = old;
      f[CABE_FLAG_N] = r[7];
      f[CABE_FLAG_Z] = (r == 8'h00);
      f[CABE_FLAG_V] = 1'b0;
      f[CABE_FLAG_S] = r[7];
      return f;
   endfunction

   function automatic logic [7:0] arith_flags(input logic [7:0] old, input logic [7:0] r,
                                              input logic c, input logic h, input logic v,
                                              input logic z_chain);
      logic [7:0] f;
      f = old;
      f[CABE_FLAG_N] = r[7];
      f[CABE_FLAG_Z] = (r == 8'h00) & (z_chain ? old[CABE_FLAG_Z] : 1'b1);
      f[CABE_FLAG_V] = v;
      f[CABE_FLAG_S] = r[7] ^ v;
      f[CABE_FLAG_C] = c;
      f[CABE_FLAG_H] = h;
      return f;
   endfunction

   // ******
   // Operation decode
   // ******
   always_comb begin
      next_flags = status_flags;
      next_wb = '0;
      next_wb.reg_idx = cmd.dst_idx;
      next_wb.pair_idx = cmd.dst_idx;
      next_flow = '0;
      next_flow.pc_load = 1'b1;
      next_flow.pc = pc_plus1;
      next_flow.push_addr = stack_ptr;
      next_flow.push_data = pc_plus1;
      next_io = '0;
      next_io.io_addr = cmd.io_addr;
      next_refused = 1'b0;
      next_sp_call = 1'b0;
      next_cycles = CABE_CYC_ONE;
      unique case (cmd.op)
         op_none: begin
         end
         op_sum, op_sum_carry: begin
            next_wb.reg_we = 1'b1;
            next_wb.reg_data = arith_res;
            next_flags = arith_flags(status_flags, arith_res, arith_c, arith_h, arith_v, 1'b0);
         end
         op_minus, op_minus_regs_borrow: begin
            next_wb.reg_we = 1'b1;
            next_wb.reg_data = arith_res;
            next_flags = arith_flags(status_flags, arith_res, arith_c, arith_h, arith_v,
                                     cmd.op == op_minus_regs_borrow);
         end
         op_compare, op_compare_carry: begin
            next_flags = arith_flags(status_flags, arith_res, arith_c, arith_h, arith_v,
                                     cmd.op == op_compare_carry);
         end
         op_and, op_or, op_xor: begin
            next_wb.reg_we = 1'b1;
            if (cmd.op == op_and) begin
               next_wb.reg_data = cmd.dst_val & opnd_b;
            end else if (cmd.op == op_or) begin
               next_wb.reg_data = cmd.dst_val | opnd_b;
            end else begin
               next_wb.reg_data = cmd.dst_val ^ opnd_b;
            end
            next_flags = logic_flags(status_flags, next_wb.reg_data);
         end
         op_mask_clear_bits: begin
            next_wb.reg_we = 1'b1;
            next_wb.reg_data = cmd.dst_val & (CABE_BYTE_ONES - cmd.imm);
            next_flags = logic_flags(status_flags, next_wb.reg_data);
         end
         op_self_and_check: begin
            next_wb.reg_we = 1'b1;
            next_wb.reg_data = cmd.dst_val & cmd.dst_val;
            next_flags = logic_flags(status_flags, next_wb.reg_data);
         end
         op_self_xor_clear: begin
            next_wb.reg_we = 1'b1;
            next_wb.reg_data = cmd.dst_val ^ cmd.dst_val;
            next_flags = logic_flags(status_flags, next_wb.reg_data);
         end
         op_word_imm_sum, op_word_imm_minus: begin
            next_cycles = CABE_CYC_TWO;
            next_wb.pair_we = 1'b1;
            next_wb.pair_data = (cmd.op == op_word_imm_sum) ? word_sum : word_dif;
            next_flags[CABE_FLAG_N] = next_wb.pair_data[15];
            next_flags[CABE_FLAG_Z] = (next_wb.pair_data == 16'h0000);
            if (cmd.op == op_word_imm_sum) begin
               next_flags[CABE_FLAG_V] = ~cmd.pair_val[15] & word_sum[15];
               next_flags[CABE_FLAG_C] = cmd.pair_val[15] & ~word_sum[15];
            end else begin
               next_flags[CABE_FLAG_V] = cmd.pair_val[15] & ~word_dif[15];
               next_flags[CABE_FLAG_C] = ~cmd.pair_val[15] & word_dif[15];
            end
            next_flags[CABE_FLAG_S] = next_flags[CABE_FLAG_N] ^ next_flags[CABE_FLAG_V];
         end
         op_product_unsigned, op_product_signed, op_product_mixed,
         op_frac_product_unsigned, op_frac_product_signed, op_frac_product_mixed: begin
            next_cycles = CABE_CYC_TWO;
            next_wb.pair_we = 1'b1;
            next_wb.pair_idx = 5'h00;
            next_wb.pair_data = mul_out;
            next_flags[CABE_FLAG_C] = mul_p[15];
            next_flags[CABE_FLAG_Z] = (mul_out == 16'h0000);
         end
         op_near_call: begin
            next_cycles = CABE_CYC_THREE;
            next_flow.pc = pc_rel;
            next_flow.push_we = 1'b1;
            next_sp_call = 1'b1;
         end
         op_jump_via_pointer: begin
            next_cycles = CABE_CYC_TWO;
            next_flow.pc = cmd.z_ptr[CABE_PC_W-1:0];
         end
         op_equal_skip_compare: begin
            if (cmd.dst_val == cmd.src_val) begin
               next_cycles = skip_cycles;
               next_flow.pc = pc_skip;
            end
         end
         op_skip_reg_bit_clear, op_skip_reg_bit_set: begin
            if (cmd.src_val[cmd.bit_sel] == (cmd.op == op_skip_reg_bit_set)) begin
               next_cycles = skip_cycles;
               next_flow.pc = pc_skip;
            end
         end
         op_skip_io_bit_clear, op_skip_io_bit_set: begin
            if (!io_ok) begin
               next_refused = 1'b1;
            end else if (cmd.io_val[cmd.bit_sel] == (cmd.op == op_skip_io_bit_set)) begin
               next_cycles = skip_cycles;
               next_flow.pc = pc_skip;
            end
         end
         op_branch_flag_set, op_branch_flag_clear: begin
            if (status_flags[cmd.bit_sel] == (cmd.op == op_branch_flag_set)) begin
               next_cycles = CABE_CYC_TWO;
               next_flow.pc = pc_rel;
            end
         end
         op_branch_signed_ge, op_branch_signed_lt: begin
            if ((status_flags[CABE_FLAG_N] ^ status_flags[CABE_FLAG_V]) ==
                (cmd.op == op_branch_signed_lt)) begin
               next_cycles = CABE_CYC_TWO;
               next_flow.pc = pc_rel;
            end
         end
         op_branch_same_higher, op_branch_lower: begin
            if (status_flags[CABE_FLAG_C] == (cmd.op == op_branch_lower)) begin
               next_cycles = CABE_CYC_TWO;
               next_flow.pc = pc_rel;
            end
         end
         op_io_bit_set, op_io_bit_clear: begin
            if (!io_ok) begin
               next_refused = 1'b1;
            end else begin
               next_cycles = CABE_CYC_TWO;
               next_io.io_we = 1'b1;
               // Whole byte written back, so set flags in it are rewritten as one
               if (cmd.op == op_io_bit_set) begin
                  next_io.io_data = cmd.io_val | bit_mask;
               end else begin
                  next_io.io_data = cmd.io_val & ~bit_mask;
               end
            end
         end
         default: begin
            next_refused = 1'b1;
         end
      endcase
   end

   // ******
   // Issue sequencer
   // ******
   always_ff @(posedge clk) begin
      if (rst) begin
         cmd_ready <= 1'b1;
         cyc_left <= 2'h0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (accept) begin
            if (next_cycles == CABE_CYC_ONE) begin
               done <= 1'b1;
            end else begin
               cmd_ready <= 1'b0;
               cyc_left <= next_cycles - CABE_CYC_ONE;
            end
         end else if (cyc_left != 2'h0) begin
            cyc_left <= cyc_left - 2'h1;
            if (cyc_left == CABE_CYC_ONE) begin
               done <= 1'b1;
               cmd_ready <= 1'b1;
            end
         end
      end
   end

   // ******
   // Result holding
   // ******
   always_ff @(posedge clk) begin
      if (rst) begin
         wb <= '0;
         flow <= '0;
         io_wr <= '0;
         io_refused <= 1'b0;
      end else if (accept) begin
         wb <= next_wb;
         flow <= next_flow;
         io_wr <= next_io;
         io_refused <= next_refused;
      end
   end

   // ******
   // Status flags and stack pointer
   // ******
   always_ff @(posedge clk) begin
      if (rst) begin
         status_flags <= CABE_STATUS_FLAGS_RST;
      end else if (reg_wr && reg_addr == CABE_STATUS_FLAGS_OFS) begin
         status_flags <= reg_wdata;
      end else if (accept) begin
         status_flags <= next_flags;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         stack_ptr <= CABE_SP_RST;
      end else if (reg_wr && reg_addr == CABE_SPL_OFS) begin
         stack_ptr <= {stack_ptr[15:8], reg_wdata};
      end else if (reg_wr && reg_addr == CABE_SPH_OFS) begin
         stack_ptr <= {reg_wdata, stack_ptr[7:0]} & 16'((17'h1_0000 >> (16 - SP_W)) - 17'h1);
      end else if (accept && next_sp_call) begin
         // Return address is pushed at the old top, then the pointer drops by two
         stack_ptr <= (stack_ptr - CABE_CALL_SP_STEP) &
                      16'((17'h1_0000 >> (16 - SP_W)) - 17'h1);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         status_flags_out <= CABE_STATUS_FLAGS_RST;
         stack_ptr_out <= CABE_SP_RST;
      end else begin
         status_flags_out <= (reg_wr && reg_addr == CABE_STATUS_FLAGS_OFS) ? reg_wdata :
                             (accept ? next_flags : status_flags);
         stack_ptr_out <= stack_ptr;
      end
   end

   // ******
   // Register read port
   // ******
   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            CABE_SPL_OFS: reg_rdata <= stack_ptr[7:0];
            CABE_SPH_OFS: reg_rdata <= stack_ptr[15:8];
            CABE_STATUS_FLAGS_OFS: reg_rdata <= status_flags;
            default: reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

endmodule

// file: cabe_far.sv
// Register file, stack and I/O space model behind the execution block
module cabe_far
   import cabe_pkg::*;
(
   input wire logic clk,
   input wire logic done,
   input wire cabe_wb_t wb,
   input wire cabe_flow_t flow,
   input wire cabe_io_t io_wr
);
   logic [7:0] regs [32];
   logic [7:0] io_space [64];
   logic [CABE_PC_W-1:0] stack [1024];
   // Results land only on the completion pulse
   always @(posedge clk) begin
      if (done && wb.reg_we) begin
         regs[wb.reg_idx] <= wb.reg_data;
      end
      if (done && wb.pair_we) begin
         {regs[wb.pair_idx + 5'h01], regs[wb.pair_idx]} <= wb.pair_data;
      end
      if (done && flow.push_we) begin
         stack[flow.push_addr[9:0]] <= flow.push_data;
      end
      if (done && io_wr.io_we) begin
         io_space[io_wr.io_addr] <= io_wr.io_data;
      end
   end
endmodule

// file: cabe_exec_props.sv
// Port checks for the execution datapath
module cabe_exec_props
   import cabe_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic cmd_valid,
   input wire cabe_cmd_t cmd,
   input wire logic cmd_ready,
   input wire logic done,
   input wire cabe_wb_t wb,
   input wire cabe_flow_t flow,
   input wire cabe_io_t io_wr,
   input wire logic io_refused,
   input wire logic [7:0] status_flags_out
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   logic acc;
   logic [7:0] sf;
   assign acc = cmd_valid && cmd_ready;
   assign sf = status_flags_out;
   sequence s_w1;
      (!cmd_ready && !done) ##1 (cmd_ready && done);
   endsequence
   sequence s_w2;
      (!cmd_ready && !done)[*2] ##1 (cmd_ready && done);
   endsequence
   property p_sum;
      acc && cmd.op == op_sum |=> done && cmd_ready && wb.reg_we && flow.pc == $past(cmd.pc) + 12'h001;
   endproperty
   a_sum: assert property (p_sum) else $error("sum");
   property p_mul;
      acc && cmd.op == op_product_unsigned |=> s_w1 ##0 (wb.pair_we && wb.pair_idx == 5'h00);
   endproperty
   a_mul: assert property (p_mul) else $error("product");
   property p_frac;
      acc && cmd.op == op_frac_product_unsigned |=> ##1
         wb.pair_data == ($past(cmd.dst_val, 2) * $past(cmd.src_val, 2)) << 1;
   endproperty
   a_frac: assert property (p_frac) else $error("frac");
   property p_call;
      acc && cmd.op == op_near_call |=> (sf == $past(sf) &&
         flow.pc == $past(cmd.pc) + $past(cmd.offset) + 12'h001) ##0 s_w2;
   endproperty
   a_call: assert property (p_call) else $error("call");
   property p_jmp;
      acc && cmd.op == op_jump_via_pointer |=> (flow.pc == CABE_PC_W'($past(cmd.z_ptr))) ##0 s_w1;
   endproperty
   a_jmp: assert property (p_jmp) else $error("jump");
   property p_logic;
      acc && cmd.op inside {op_and, op_or, op_xor} |=> done && !sf[CABE_FLAG_V] &&
         sf[CABE_FLAG_C] == $past(sf[CABE_FLAG_C]);
   endproperty
   a_logic: assert property (p_logic) else $error("logic");
   property p_ioref;
      acc && cmd.op inside {op_io_bit_set, op_io_bit_clear} && cmd.io_addr > CABE_IO_BIT_MAX
         |=> done && io_refused && !io_wr.io_we;
   endproperty
   a_ioref: assert property (p_ioref) else $error("io refuse");
   property p_ioset;
      acc && cmd.op == op_io_bit_set && cmd.io_addr <= CABE_IO_BIT_MAX |=> s_w1 ##0
         (io_wr.io_we && io_wr.io_data == ($past(cmd.io_val, 2) | (8'h01 << $past(cmd.bit_sel, 2))));
   endproperty
   a_ioset: assert property (p_ioset) else $error("io set");
   property p_sge;
      acc && cmd.op == op_branch_signed_ge && !(sf[CABE_FLAG_N] ^ sf[CABE_FLAG_V])
         |=> (flow.pc == $past(cmd.pc) + $past(cmd.offset) + 12'h001) ##0 s_w1;
   endproperty
   a_sge: assert property (p_sge) else $error("signed");
   property p_skip;
      acc && cmd.op == op_equal_skip_compare && cmd.dst_val == cmd.src_val && cmd.skip_two_word
         |=> (flow.pc == $past(cmd.pc) + 12'h003) ##0 s_w2;
   endproperty
   a_skip: assert property (p_skip) else $error("skip");
endmodule

// file: cabe_exec_test.sv
// Self-checking bench for the execution datapath
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module cabe_exec_test
   import cabe_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cmd_valid = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [5:0] reg_addr = 6'h00;
   logic [7:0] reg_wdata = 8'h00;
   cabe_cmd_t cmd = '0;
   logic cmd_ready, done, io_refused;
   cabe_wb_t wb;
   cabe_flow_t flow;
   cabe_io_t io_wr;
   logic [7:0] status_flags_out, reg_rdata;
   logic [15:0] stack_ptr_out;
   int n_errors = 0;
   int samples_checked = 0;
   always #2.5 clk = ~clk;
   cabe_exec #(.SP_W(10)) DUT (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
      .cmd_ready(cmd_ready), .done(done), .wb(wb), .flow(flow), .io_wr(io_wr),
      .io_refused(io_refused), .status_flags_out(status_flags_out), .stack_ptr_out(stack_ptr_out),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata));
   cabe_far u_far (.clk(clk), .done(done), .wb(wb), .flow(flow), .io_wr(io_wr));
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      `CHK(reg_rdata, e)
   endtask
   task automatic go(input cabe_op_t o, input logic [7:0] d, input logic [7:0] s, input int n);
      int k;
      @(posedge clk);
      cmd.op <= o;
      cmd.dst_val <= d;
      cmd.src_val <= s;
      cmd.imm <= s;
      cmd_valid <= 1'b1;
      @(posedge clk);
      cmd_valid <= 1'b0;
      k = 1;
      #1;
      while (done !== 1'b1 && k < 6) begin
         @(posedge clk);
         #1;
         k++;
      end
      `CHK(k, n)
   endtask
   task automatic t_arith();
      go(op_sum, 8'h88, 8'h88, 1);
      `CHK({wb.reg_data, status_flags_out, flow.pc}, 28'h1039_101)
      go(op_sum_carry, 8'h00, 8'h00, 1);
      `CHK({wb.reg_data, status_flags_out}, 16'h0100)
      go(op_minus, 8'h10, 8'h01, 1);
      `CHK({wb.reg_data, status_flags_out}, 16'h0f20)
      cmd.use_imm = 1'b1;
      go(op_compare, 8'h10, 8'h20, 1);
      `CHK({wb.reg_we, status_flags_out}, 9'h015)
      go(op_or, 8'h00, 8'h00, 1);
      `CHK({wb.reg_data, status_flags_out}, 16'h0003)
      go(op_mask_clear_bits, 8'hff, 8'h0f, 1);
      `CHK({wb.reg_data, status_flags_out}, 16'hf015)
      go(op_self_xor_clear, 8'h55, 8'h00, 1);
      `CHK({wb.reg_data, status_flags_out}, 16'h0003)
      $display("arith ended");
   endtask
   task automatic t_mul();
      go(op_word_imm_sum, 8'h00, 8'h01, 2);
      `CHK({wb.pair_data, status_flags_out}, 24'h01_0000)
      go(op_product_unsigned, 8'hff, 8'hff, 2);
      `CHK({wb.pair_data, status_flags_out}, 24'hfe_0101)
      go(op_frac_product_unsigned, 8'h80, 8'h80, 2);
      @(posedge clk);
      #1;
      `CHK({u_far.regs[1], u_far.regs[0], status_flags_out}, 24'h80_0000)
      $display("mul ended");
   endtask
   task automatic t_flow();
      wr(CABE_SPL_OFS, 8'h50);
      wr(CABE_SPH_OFS, 8'h01);
      go(op_near_call, 8'h00, 8'h00, 3);
      `CHK({flow.pc, flow.push_data}, 24'h111_101)
      rd(CABE_SPL_OFS, 8'h4e);
      `CHK(stack_ptr_out, 16'h014e)
      `CHK(u_far.stack[336], 12'h101)
      go(op_jump_via_pointer, 8'h00, 8'h00, 2);
      `CHK(flow.pc, 12'h234)
      rd(6'h10, 8'h00);
      $display("flow ended");
   endtask
   task automatic t_branch();
      cabe_op_t ops [6] = '{op_branch_signed_ge, op_branch_signed_lt, op_branch_same_higher,
         op_branch_lower, op_branch_flag_set, op_branch_flag_clear};
      logic [2:0] bs [6] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h7, 3'h5};
      logic [5:0] tk = 6'b10_0101;
      cmd.skip_two_word = 1'b1;
      go(op_equal_skip_compare, 8'h5a, 8'h5a, 3);
      `CHK(flow.pc, 12'h103)
      cmd.skip_two_word = 1'b0;
      cmd.bit_sel = 3'h2;
      go(op_skip_reg_bit_clear, 8'hfb, 8'hfb, 2);
      `CHK(flow.pc, 12'h102)
      go(op_skip_reg_bit_set, 8'hfb, 8'hfb, 1);
      `CHK(flow.pc, 12'h101)
      wr(CABE_STATUS_FLAGS_OFS, 8'h0c);
      rd(CABE_STATUS_FLAGS_OFS, 8'h0c);
      for (int i = 0; i < 6; i++) begin
         cmd.bit_sel = bs[i];
         go(ops[i], 8'h00, 8'h00, tk[i] ? 2 : 1);
         `CHK(flow.pc, tk[i] ? 12'h111 : 12'h101)
      end
      $display("branch ended");
   endtask
   task automatic t_io();
      cmd.io_addr = 6'h1c;
      cmd.io_val = 8'h81;
      go(op_io_bit_set, 8'h00, 8'h00, 2);
      `CHK({io_wr.io_we, io_wr.io_data, io_refused}, 10'h342)
      cmd.io_addr = 6'h20;
      go(op_io_bit_clear, 8'h00, 8'h00, 1);
      `CHK({io_wr.io_we, io_refused, flow.pc}, 14'h1101)
      cmd.io_addr = 6'h1f;
      go(op_skip_io_bit_clear, 8'h00, 8'h00, 2);
      `CHK({flow.pc, u_far.io_space[28]}, 20'h1_02a1)
      $display("io ended");
   endtask
   task automatic stop_test();
      $display("checked %0d mismatched %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      cmd.pc = 12'h100;
      cmd.offset = 12'h010;
      cmd.pair_val = 16'h00ff;
      cmd.z_ptr = 16'h0234;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rd(CABE_STATUS_FLAGS_OFS, CABE_STATUS_FLAGS_RST);
      t_arith();
      t_mul();
      t_flow();
      t_branch();
      t_io();
      stop_test();
   end
   initial begin
      #20000;
      n_errors++;
      stop_test();
   end
endmodule
bind cabe_exec cabe_exec_props u_props (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
   .cmd_ready(cmd_ready), .done(done), .wb(wb), .flow(flow), .io_wr(io_wr),
   .io_refused(io_refused), .status_flags_out(status_flags_out));
